// File: shared/itc_regs.svh
// Constants for the thermometer control block
`ifndef ITC_REGS_SVH
`define ITC_REGS_SVH
`define ITC_CLK_PERIOD_NS 100
`define ITC_T_REQ_NS 1440000
`define ITC_T_TOUT_LOW_NS 27000000
`define ITC_T_TOUT_HIGH_NS 45000
`define ITC_T_PWM_STEP_NS 1000
`define ITC_PWM_P_ZERO 8'h0080
`define ITC_PWM_FULL 10'h3FF
`define ITC_FIR_WIN 8'hFF
`define ITC_SCALE_SHIFT 7
`define ITC_CMD_AMB 8'h06
`define ITC_CMD_OBJ 8'h07
`define ITC_CELL_ONCHIP_TEMP_SENSOR 2'h0
`define ITC_CELL_IR1 2'h1
`define ITC_CELL_IR2 2'h2
`define ITC_TX_IDLE 8'hFF
`endif

// File: shared/itc_pkg.sv
// Types for the thermometer control block
package itc_pkg;
  typedef enum logic [4:0] {
    MS_AMB = 5'b00001,
    MS_IR1 = 5'b00010,
    MS_IR2 = 5'b00100,
    MS_CALC = 5'b01000,
    MS_LOAD = 5'b10000
  } itc_meas_t;
  typedef enum logic [6:0] {
    BS_IDLE = 7'b0000001,
    BS_ADDR = 7'b0000010,
    BS_AACK = 7'b0000100,
    BS_CMD = 7'b0001000,
    BS_CACK = 7'b0010000,
    BS_TX = 7'b0100000,
    BS_MACK = 7'b1000000
  } itc_bus_t;
endpackage : itc_pkg

// File: src/itc_top.sv
// Thermometer digital control: measurement sequencing, two-wire target, PWM and pin mux
`timescale 1ns/10ps
`include "itc_regs.svh"
module itc_top
  import itc_pkg::*;
#(
  parameter int REQ_CYC = (`ITC_T_REQ_NS + `ITC_CLK_PERIOD_NS - 1) / `ITC_CLK_PERIOD_NS,
  parameter int TLOW_CYC = (`ITC_T_TOUT_LOW_NS + `ITC_CLK_PERIOD_NS - 1) / `ITC_CLK_PERIOD_NS
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sd_bit_in,
  input wire logic pwm_enable_in,
  input wire logic pwm_single_in,
  input wire logic pwm_push_pull_in,
  input wire logic relay_mode_in,
  input wire logic [6:0] pwm_period_mult_in,
  input wire logic [1:0] iir_shift_in,
  input wire logic [15:0] obj_min_in,
  input wire logic [15:0] obj_max_in,
  input wire logic [3:0] pwm_range_shift_in,
  input wire logic [6:0] target_bus_address_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  output logic [1:0] sensor_sel_out,
  output logic [15:0] ambient_temperature_out,
  output logic [15:0] object_temperature_out,
  output logic meas_done_out,
  output logic serial_mode_out
);
  localparam int THIGH_CYC = (`ITC_T_TOUT_HIGH_NS + `ITC_CLK_PERIOD_NS - 1) / `ITC_CLK_PERIOD_NS;
  localparam int STEP_CYC = `ITC_T_PWM_STEP_NS / `ITC_CLK_PERIOD_NS;

  function automatic logic [15:0] iir_step(input logic [15:0] y, input logic [15:0] x, input logic [1:0] k);
    logic [16:0] d;
    d = {1'b0, x} - {1'b0, y};
    iir_step = 16'(17'(y) + 17'($signed(d) >>> k));
  endfunction : iir_step

  function automatic logic [9:0] pwm_scale(input logic [15:0] t, input logic [15:0] lo, input logic [3:0] sh);
    logic [15:0] v;
    v = (t > lo) ? ((t - lo) >> sh) : 16'h0000;
    pwm_scale = (v > 16'(`ITC_PWM_FULL)) ? `ITC_PWM_FULL : v[9:0];
  endfunction : pwm_scale

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync_reg, sda_sync_reg, sd_sync_reg;
  logic scl_d_reg, sda_d_reg;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Data pin sits low during reset
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b00;
      sd_sync_reg <= 2'b00;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      sd_sync_reg <= {sd_sync_reg[0], sd_bit_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------
  // Measurement sequencer and filters
  // ----------------------------------------
  itc_meas_t meas_reg;
  logic [15:0] ram_reg [0:2];
  logic [7:0] win_reg;
  logic [8:0] acc_reg;
  logic [9:0] duty_reg;
  logic relay_lvl_reg;
  wire [15:0] fir_out = 16'(acc_reg) << `ITC_SCALE_SHIFT;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meas_reg <= MS_AMB;
      win_reg <= 8'h00;
      acc_reg <= 9'h000;
      sensor_sel_out <= `ITC_CELL_ONCHIP_TEMP_SENSOR;
      meas_done_out <= 1'b0;
      ram_reg[0] <= 16'h0000;
      ram_reg[1] <= 16'h0000;
      ram_reg[2] <= 16'h0000;
    end else begin
      meas_done_out <= 1'b0;
      unique case (meas_reg)
        MS_AMB, MS_IR1, MS_IR2: begin
          acc_reg <= 9'(acc_reg + {8'h00, sd_sync_reg[1]});
          win_reg <= 8'(win_reg + 8'h01);
          if (win_reg == `ITC_FIR_WIN) begin
            acc_reg <= 9'h000;
            ram_reg[sensor_sel_out] <= iir_step(ram_reg[sensor_sel_out], fir_out, iir_shift_in);
            unique case (meas_reg)
              MS_AMB: begin
                meas_reg <= MS_IR1;
                sensor_sel_out <= `ITC_CELL_IR1;
              end
              MS_IR1: begin
                meas_reg <= MS_IR2;
                sensor_sel_out <= `ITC_CELL_IR2;
              end
              default: begin
                meas_reg <= MS_CALC;
                sensor_sel_out <= `ITC_CELL_ONCHIP_TEMP_SENSOR;
              end
            endcase
          end
        end
        MS_CALC: meas_reg <= MS_LOAD;
        MS_LOAD: begin
          meas_reg <= MS_AMB;
          meas_done_out <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ambient_temperature_out <= 16'h0000;
      object_temperature_out <= 16'h0000;
      duty_reg <= 10'h000;
      relay_lvl_reg <= 1'b0;
    end else if (meas_reg == MS_CALC) begin
      ambient_temperature_out <= ram_reg[`ITC_CELL_ONCHIP_TEMP_SENSOR];
      object_temperature_out <= 16'(ram_reg[`ITC_CELL_IR1] - ram_reg[`ITC_CELL_IR2] + ram_reg[`ITC_CELL_ONCHIP_TEMP_SENSOR]);
    end else if (meas_reg == MS_LOAD) begin
      duty_reg <= pwm_scale(object_temperature_out, obj_min_in, pwm_range_shift_in);
      relay_lvl_reg <= object_temperature_out >= obj_max_in;
    end
  end

  // ----------------------------------------
  // Free-running PWM
  // ----------------------------------------
  logic [8:0] step_mul;
  logic [15:0] pre_reg;
  logic [9:0] pos_reg;
  logic pwm_lvl_reg;
  always_comb begin
    step_mul = (pwm_period_mult_in == 7'h00) ? 9'(`ITC_PWM_P_ZERO) : {2'b00, pwm_period_mult_in};
    if (!pwm_single_in) begin
      step_mul = 9'(step_mul << 1);
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_reg <= 16'h0000;
      pos_reg <= 10'h000;
      pwm_lvl_reg <= 1'b0;
    end else begin
      if (pre_reg >= 16'(STEP_CYC * step_mul - 1)) begin
        pre_reg <= 16'h0000;
        pos_reg <= 10'(pos_reg + 10'h001);
        pwm_lvl_reg <= pos_reg < duty_reg;
      end else begin
        pre_reg <= 16'(pre_reg + 16'h0001);
      end
    end
  end

  // ----------------------------------------
  // Two-wire target
  // ----------------------------------------
  itc_bus_t bus_reg;
  logic [7:0] rx_reg, cmd_reg, tx_reg;
  logic [3:0] bit_reg;
  logic [1:0] byte_reg;
  logic rw_reg, nack_reg, drive_low_reg, forced_reg;
  logic [18:0] low_cnt_reg;
  logic [9:0] high_cnt_reg;
  logic [15:0] rd_word;
  always_comb begin
    unique case (cmd_reg)
      `ITC_CMD_AMB: rd_word = ambient_temperature_out;
      `ITC_CMD_OBJ: rd_word = object_temperature_out;
      8'h00, 8'h01, 8'h02: rd_word = ram_reg[cmd_reg[1:0]];
      default: rd_word = 16'h0000;
    endcase
  end
  wire tout_low = low_cnt_reg >= 19'(TLOW_CYC);
  wire tout_high = (bus_reg != BS_IDLE) && (high_cnt_reg >= 10'(THIGH_CYC));

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_cnt_reg <= 19'h0_0000;
      high_cnt_reg <= 10'h000;
      forced_reg <= 1'b0;
    end else begin
      low_cnt_reg <= scl_s ? 19'h0_0000 : (tout_low ? low_cnt_reg : 19'(low_cnt_reg + 19'h0_0001));
      high_cnt_reg <= (!scl_s || bus_reg == BS_IDLE) ? 10'h000 : 10'(high_cnt_reg + 10'h001);
      if (low_cnt_reg >= 19'(REQ_CYC)) begin
        forced_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_reg <= BS_IDLE;
      rx_reg <= 8'h00;
      cmd_reg <= 8'h00;
      tx_reg <= `ITC_TX_IDLE;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (tout_low || tout_high || bus_stop || !serial_mode_out) begin
      bus_reg <= BS_IDLE;
      drive_low_reg <= 1'b0;
    end else if (bus_start) begin
      bus_reg <= BS_ADDR;
      bit_reg <= 4'h0;
      drive_low_reg <= 1'b0;
    end else if (scl_rise) begin
      if (bus_reg == BS_ADDR || bus_reg == BS_CMD) begin
        rx_reg <= {rx_reg[6:0], sda_s};
        bit_reg <= 4'(bit_reg + 4'h1);
      end
      if (bus_reg == BS_MACK) begin
        nack_reg <= sda_s;
      end
    end else if (scl_fall) begin
      unique case (bus_reg)
        BS_IDLE: drive_low_reg <= 1'b0;
        BS_ADDR: if (bit_reg == 4'h8) begin
          if (rx_reg[7:1] == target_bus_address_in) begin
            bus_reg <= BS_AACK;
            rw_reg <= rx_reg[0];
            drive_low_reg <= 1'b1;
          end else begin
            bus_reg <= BS_IDLE;
          end
        end
        BS_AACK: begin
          bit_reg <= 4'h0;
          byte_reg <= 2'h0;
          if (rw_reg) begin
            bus_reg <= BS_TX;
            tx_reg <= {rd_word[6:0], 1'b0};
            drive_low_reg <= ~rd_word[7];
          end else begin
            bus_reg <= BS_CMD;
            drive_low_reg <= 1'b0;
          end
        end
        BS_CMD: if (bit_reg == 4'h8) begin
          if (byte_reg == 2'h0) begin
            cmd_reg <= rx_reg;
          end
          bus_reg <= BS_CACK;
          drive_low_reg <= 1'b1;
        end
        BS_CACK: begin
          bus_reg <= BS_CMD;
          bit_reg <= 4'h0;
          byte_reg <= 2'h1;
          drive_low_reg <= 1'b0;
        end
        BS_TX: if (bit_reg == 4'h7) begin
          bus_reg <= BS_MACK;
          drive_low_reg <= 1'b0;
        end else begin
          bit_reg <= 4'(bit_reg + 4'h1);
          drive_low_reg <= ~tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b1};
        end
        BS_MACK: if (nack_reg) begin
          bus_reg <= BS_IDLE;
        end else begin
          bus_reg <= BS_TX;
          bit_reg <= 4'h0;
          byte_reg <= 2'h1;
          tx_reg <= (byte_reg == 2'h0) ? {rd_word[14:8], 1'b1} : `ITC_TX_IDLE;
          drive_low_reg <= (byte_reg == 2'h0) ? ~rd_word[15] : 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Shared pin function
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_mode_out <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_b_out <= 1'b0;
    end else begin
      serial_mode_out <= !pwm_enable_in || forced_reg;
      if (!pwm_enable_in || forced_reg) begin
        sda_out <= 1'b0;
        sda_oe_b_out <= ~drive_low_reg;
      end else begin
        sda_out <= relay_mode_in ? relay_lvl_reg : pwm_lvl_reg;
        sda_oe_b_out <= pwm_push_pull_in ? 1'b0 : (relay_mode_in ? relay_lvl_reg : pwm_lvl_reg);
      end
    end
  end
endmodule : itc_top

// File: dv/itc_top_asserts.sv
// Port checker for the thermometer control block
`timescale 1ns/10ps
module itc_top_asserts
  import itc_pkg::*;
#(
  parameter int REQ_CYC = 50,
  parameter int TLOW_CYC = 200
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic pwm_enable_in,
  input wire logic pwm_push_pull_in,
  input wire logic sda_out,
  input wire logic sda_oe_b_out,
  input wire logic [1:0] sensor_sel_out,
  input wire logic [15:0] ambient_temperature_out,
  input wire logic meas_done_out,
  input wire logic serial_mode_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [15:0] gap_reg;
  logic seen_reg;
  // Cycles since the last end of measurement
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap_reg <= 16'h0000;
      seen_reg <= 1'b0;
    end else if (meas_done_out) begin
      gap_reg <= 16'h0000;
      seen_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  sequence s_pp;
    (!serial_mode_out && pwm_push_pull_in) [*3];
  endsequence
  sequence s_od;
    (!serial_mode_out && !pwm_push_pull_in) [*3];
  endsequence
  sequence s_hold;
    $stable(sensor_sel_out) [*8];
  endsequence
  a_por_pin_low: assert property ($rose(rst_b_in) |-> !$past(sda_oe_b_out) && !$past(sda_out))
    else $error("pin not held low in reset");
  a_mode_after_por: assert property ($rose(rst_b_in) |=> serial_mode_out == !$past(pwm_enable_in))
    else $error("pin function not taken from config");
  a_pp_drive: assert property (s_pp |-> !sda_oe_b_out)
    else $error("push-pull output not driven");
  a_pwm_od: assert property (s_od |-> sda_oe_b_out || !sda_out)
    else $error("open-drain output drives high");
  a_serial_od: assert property (serial_mode_out |-> sda_oe_b_out || !sda_out)
    else $error("serial data driven high");
  a_meas_period: assert property (meas_done_out && seen_reg |-> gap_reg == 16'h0301)
    else $error("measurement cycle length wrong");
  a_done_pulse: assert property (meas_done_out |=> !meas_done_out)
    else $error("end of cycle pulse too long");
  a_sel_order: assert property ($changed(sensor_sel_out) |-> sensor_sel_out != 2'h3 &&
    (sensor_sel_out == $past(sensor_sel_out) + 2'h1 || sensor_sel_out == 2'h0))
    else $error("channel order wrong");
  a_sel_hold: assert property ($changed(sensor_sel_out) |=> s_hold)
    else $error("channel switched too soon");
  a_result_on_done: assert property ($changed(ambient_temperature_out) |-> ##[0:2] meas_done_out)
    else $error("result changed outside cycle end");
  a_idle_quiet: assert property ((serial_mode_out && scl_in && sda_in) [*8] |-> sda_oe_b_out)
    else $error("target drives idle bus");
endmodule : itc_top_asserts
bind itc_top itc_top_asserts #(.REQ_CYC(REQ_CYC), .TLOW_CYC(TLOW_CYC)) u_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_in(sda_in),
  .pwm_enable_in(pwm_enable_in), .pwm_push_pull_in(pwm_push_pull_in), .sda_out(sda_out),
  .sda_oe_b_out(sda_oe_b_out), .sensor_sel_out(sensor_sel_out),
  .ambient_temperature_out(ambient_temperature_out), .meas_done_out(meas_done_out),
  .serial_mode_out(serial_mode_out));

// File: dv/itc_host_model.sv
// Two-wire bus host model; clock stands high between frames
`timescale 1ns/10ps
module itc_host_model (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // One 800 ns bit, sampled at the end of the high phase
  task automatic bus_bit(input logic b, output logic r);
    #100 sda_low_out = !b;
    #400 scl_out = 1'b1;
    #300 r = sda_in;
    scl_out = 1'b0;
  endtask : bus_bit
  task automatic bus_start();
    sda_low_out = 1'b0;
    #800 scl_out = 1'b1;
    #400 sda_low_out = 1'b1;
    #400 scl_out = 1'b0;
  endtask : bus_start
  task automatic bus_byte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bus_bit(d[i], r[i]);
    end
    bus_bit(a, k);
  endtask : bus_byte
  // Write command then repeated start and read a word
  task automatic read_word(input logic [6:0] ad, input logic [7:0] c, output logic [15:0] w, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    bus_start();
    bus_byte({ad, 1'b0}, 1'b1, r, k0);
    bus_byte(c, 1'b1, r, k1);
    bus_start();
    bus_byte({ad, 1'b1}, 1'b1, r, k2);
    bus_byte(8'hFF, 1'b0, w[7:0], k3);
    bus_byte(8'hFF, 1'b1, w[15:8], k3);
    bus_stop();
    ok = !k0 && !k1 && !k2;
  endtask : read_word
  task automatic bus_stop();
    #100 sda_low_out = 1'b1;
    #700 scl_out = 1'b1;
    #400 sda_low_out = 1'b0;
  endtask : bus_stop
  // Command then a data word, low byte first
  task automatic write_word(input logic [6:0] ad, input logic [7:0] c, input logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    bus_start();
    bus_byte({ad, 1'b0}, 1'b1, r, k0);
    bus_byte(c, 1'b1, r, k1);
    bus_byte(d[7:0], 1'b1, r, k2);
    bus_byte(d[15:8], 1'b1, r, k3);
    bus_stop();
    ok = !k0 && !k1 && !k2 && !k3;
  endtask : write_word
  task automatic hold_sda(input int ns);
    sda_low_out = 1'b1;
    #(ns) sda_low_out = 1'b0;
  endtask : hold_sda
  task automatic hold_scl(input int ns);
    scl_out = 1'b0;
    #(ns) scl_out = 1'b1;
  endtask : hold_scl
endmodule : itc_host_model

// File: dv/itc_top_tb_top.sv
// Testbench for the thermometer control block
`timescale 1ns/10ps
`include "itc_regs.svh"
module itc_top_tb_top
  import itc_pkg::*;
;
  localparam int REQ = 50;
  localparam logic [6:0] ADDR = 7'h5A;
  // Settled result with the bitstream held at one
  localparam logic [15:0] FULL_T = 16'(`ITC_FIR_WIN) << `ITC_SCALE_SHIFT;
  logic clk = 1'b0, rst_b = 1'b0, sd = 1'b1, en = 1'b0, single = 1'b1, pp = 1'b0, relay = 1'b0;
  logic [6:0] mult = 7'h01;
  logic [15:0] omin = 16'h0000, omax = 16'h0000, amb, obj;
  logic scl, sda_low, sda_o, oe_b, done, smode;
  logic [1:0] sel;
  int n_mismatch = 0, n_tests = 0;
  wire sda_pin = !(sda_low || (!oe_b && !sda_o));
  always #50 clk = ~clk;
  itc_host_model u_host (.sda_in(sda_pin), .scl_out(scl), .sda_low_out(sda_low));
  itc_top #(.REQ_CYC(REQ), .TLOW_CYC(200)) u_dut (.core_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl),
    .sda_in(sda_pin), .sd_bit_in(sd), .pwm_enable_in(en), .pwm_single_in(single), .pwm_push_pull_in(pp),
    .relay_mode_in(relay), .pwm_period_mult_in(mult), .iir_shift_in(2'h0), .obj_min_in(omin), .obj_max_in(omax),
    .pwm_range_shift_in(4'h0), .target_bus_address_in(ADDR), .sda_out(sda_o), .sda_oe_b_out(oe_b),
    .sensor_sel_out(sel), .ambient_temperature_out(amb), .object_temperature_out(obj), .meas_done_out(done),
    .serial_mode_out(smode));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step_until(input logic want, input int lim, output int n);
    n = 0;
    while ((done !== want) && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      chk("wait_timeout", 0, 1);
      tally_and_finish();
    end
  endtask : step_until
  task automatic por(input logic e, input logic p);
    @(negedge clk);
    en = e;
    pp = p;
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    chk("reset_pin", {oe_b, sda_o, done, obj}, 0);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    chk("serial_mode", smode, !e);
  endtask : por
  task automatic next_done();
    int n;
    step_until(1'b1, 2000, n);
    @(negedge clk);
  endtask : next_done
  task automatic t_meas();
    int n;
    next_done();
    step_until(1'b1, 2000, n);
    chk("meas_cycle", n + 1, 770);
  endtask : t_meas
  task automatic t_bus();
    logic [15:0] w;
    logic ok;
    for (int i = 0; i < 4; i++) begin
      u_host.read_word(ADDR, i == 0 ? 8'h06 : i == 1 ? 8'h07 : i == 2 ? 8'h01 : 8'h1F, w, ok);
      chk("bus_ack", ok, 1);
      chk("bus_word", w, i == 3 ? 16'h0000 : FULL_T);
    end
    u_host.read_word(ADDR ^ 7'h01, 8'h06, w, ok);
    chk("foreign_addr_ack", ok, 0);
  endtask : t_bus
  task automatic t_tout();
    logic [7:0] r;
    logic k;
    u_host.bus_start();
    u_host.bus_byte({ADDR, 1'b1}, 1'b1, r, k);
    chk("tout_ack", k, 0);
    fork
      u_host.hold_scl(30000);
      begin
        repeat (100) @(negedge clk);
        chk("tout_drive", sda_pin, 0);
        repeat (150) @(negedge clk);
        chk("tout_release", sda_pin, 1);
      end
    join
  endtask : t_tout
  // Erase and write times scaled down
  task automatic t_wake_write();
    logic [15:0] w;
    logic ok;
    u_host.hold_sda(5000);
    repeat (10) @(negedge clk);
    u_host.write_word(ADDR, 8'h21, 16'h0000, ok);
    chk("erase_ack", ok, 1);
    repeat (100) @(negedge clk);
    u_host.write_word(ADDR, 8'h21, 16'h1234, ok);
    chk("write_ack", ok, 1);
    repeat (100) @(negedge clk);
    u_host.read_word(ADDR, 8'h06, w, ok);
    chk("wake_ack", ok, 1);
    chk("wake_word", w, FULL_T);
  endtask : t_wake_write
  task automatic t_forced();
    logic [15:0] w;
    logic ok;
    u_host.hold_scl((REQ + 10) * 100);
    repeat (4) @(negedge clk);
    chk("forced_serial", smode, 1);
    u_host.read_word(ADDR, 8'h07, w, ok);
    chk("forced_ack", ok, 1);
    chk("forced_word", w, FULL_T);
  endtask : t_forced
  task automatic t_pwm(input logic s);
    int hi, per;
    single = s;
    relay = 1'b0;
    por(1'b1, 1'b1);
    next_done();
    omin = FULL_T - 16'h0001;
    next_done();
    next_done();
    hi = 0;
    while (sda_o !== 1'b0 && hi < 30000) begin
      @(negedge clk);
      hi++;
    end
    while (sda_o !== 1'b1 && hi < 60000) begin
      @(negedge clk);
      hi++;
    end
    hi = 0;
    while (sda_o === 1'b1 && hi < 100) begin
      @(negedge clk);
      hi++;
    end
    per = hi;
    while (sda_o !== 1'b1 && per < 50000) begin
      @(negedge clk);
      per++;
    end
    chk("pwm_high", hi, s ? 10 : 20);
    chk("pwm_period", per, s ? 10240 : 20480);
  endtask : t_pwm
  task automatic t_relay();
    for (int i = 0; i < 4; i++) begin
      relay = 1'b1;
      por(1'b1, i[0]);
      next_done();
      omax = i[1] ? FULL_T + 16'h0001 : 16'h0000;
      next_done();
      next_done();
      chk("relay_pin", {oe_b, sda_pin}, {!i[0] && !i[1], !i[1]});
    end
  endtask : t_relay
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    por(1'b0, 1'b0);
    t_meas();
    t_bus();
    t_tout();
    t_wake_write();
    t_pwm(1'b1);
    t_pwm(1'b0);
    t_relay();
    t_forced();
    tally_and_finish();
  end
endmodule : itc_top_tb_top
